// [pint_regs.svh]
// register offsets, field positions, reset values and slice codes of the pin interrupt block
// assumes a 32-bit apb slave with byte addresses; included by the design file and the bench
//
// Contract
// - eight channels, each picking its source through its own pin select setting
// - a channel source is a pin number of port 0 or port 1
// - channel inputs come straight from the pad, whatever the pin function
// - pin interrupt mode: each channel raises its own request on edge or level
// - pattern engine has eight slices, each one term of one minterm
// - each slice selects an input and its detector watches it continuously
// - sticky slice catches rising, falling or either edge since last clear
// - sticky slice output stays high until detect logic is cleared
// - event slice output is high one cycle per edge, then rearms
// - level slice is true while input is at configured high or low level
// - full minterm match asserts the request of the minterm's last slice
// - each minterm has its own request; any match raises requests
// - when enabled, receive event to the core follows any minterm match
// - or of all minterms drives receive event and the any-match output
// - one control bit picks pin or pattern requests, never both
// - receive event stays enableable while pin interrupts own the request lines
// - pattern match needs the clock; only pin interrupts may request wake-up
// - sticky plus event slice gives request on edge after a qualifying edge
// - level plus event slice limits edge requests to the level window
// - per-channel sense bit: 0 edge, 1 level, reset 0
// - per-channel enable bit enables rising edge or level request, 1 enables
// - in level mode a second per-channel bit picks the active level
// - ones written to set location set enable bits, zeros leave them
`ifndef PINT_REGS_SVH
`define PINT_REGS_SVH

`define OFS_SENSE_SELECT 12'h000
`define OFS_RISE_LEVEL_ENABLE 12'h004
`define OFS_RISE_LEVEL_SET 12'h008
`define OFS_RISE_LEVEL_CLEAR 12'h00c
`define OFS_FALL_ACTIVE_LEVEL 12'h010
`define OFS_FALL_ACTIVE_SET 12'h014
`define OFS_FALL_ACTIVE_CLEAR 12'h018
`define OFS_RISE_DETECT 12'h01c
`define OFS_FALL_DETECT 12'h020
`define OFS_REQUEST_STATUS 12'h024
`define OFS_MATCH_CONTROL 12'h028
`define OFS_SLICE_SOURCE 12'h02c
`define OFS_SLICE_CONFIG 12'h030
`define OFS_PIN_SELECT_BASE 12'h040
`define OFS_PIN_SELECT_LAST 12'h05c

`define RESET_BYTE 8'h00
`define RESET_WORD 32'h0000_0000
`define RESET_PIN_SELECT 6'h00

`define CTRL_MATCH_SELECT_BIT 0
`define CTRL_EVENT_ENABLE_BIT 1
`define SRC_FIELD_LSB 8
`define CFG_FIELD_LSB 8
`define FIELD_WIDTH 3

`define SLICE_ALWAYS 3'h0
`define SLICE_STICKY_RISE 3'h1
`define SLICE_STICKY_FALL 3'h2
`define SLICE_STICKY_BOTH 3'h3
`define SLICE_LEVEL_HIGH 3'h4
`define SLICE_LEVEL_LOW 3'h5
`define SLICE_NEVER 3'h6
`define SLICE_EVENT_BOTH 3'h7

`endif

// [pint_pkg.sv]
// types shared by the pin interrupt and pattern match block
// assumes eight channels fed from two 32-pin ports
package pint_pkg;
  typedef logic [7:0] chan_vec_t;
  typedef logic [5:0] pin_sel_t;
  typedef logic [2:0] field_t;
endpackage

// [pin_interrupt_pattern_match.sv]
// pin interrupt and pattern match engine with an apb register slave
// assumes pads arrive asynchronously and one 10 mhz clock runs the whole block
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pint_regs.svh"

module pin_interrupt_pattern_match
  import pint_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [63:0] pad_in,
  output logic [7:0] interrupt_request,
  output logic any_match_output,
  output logic core_receive_event,
  output logic wake_request
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------
  // pad synchronisers
  // ----------------------------------------------------------------
  // every pad is synchronised before the mux so a reselect never exposes a metastable bit
  logic [63:0] pad_meta;
  logic [63:0] pad_sync;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pad_meta <= 64'h0;
      pad_sync <= 64'h0;
    end else begin
      pad_meta <= pad_in;
      pad_sync <= pad_meta;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  chan_vec_t channel_sense_select;
  chan_vec_t rise_or_level_enable_bits;
  chan_vec_t fall_active_level_bits;
  chan_vec_t rise_detect;
  chan_vec_t fall_detect;
  logic match_select;
  logic event_enable;
  logic [31:0] slice_source;
  logic [31:0] slice_config;
  pin_sel_t channel_pin_select [8];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire setup_phase = psel && !penable;
  wire write_strobe = psel && penable && pwrite;
  wire hit_sense = paddr == `OFS_SENSE_SELECT;
  wire hit_enr = paddr == `OFS_RISE_LEVEL_ENABLE;
  wire hit_senr = paddr == `OFS_RISE_LEVEL_SET;
  wire hit_cenr = paddr == `OFS_RISE_LEVEL_CLEAR;
  wire hit_enf = paddr == `OFS_FALL_ACTIVE_LEVEL;
  wire hit_senf = paddr == `OFS_FALL_ACTIVE_SET;
  wire hit_cenf = paddr == `OFS_FALL_ACTIVE_CLEAR;
  wire hit_rise = paddr == `OFS_RISE_DETECT;
  wire hit_fall = paddr == `OFS_FALL_DETECT;
  wire hit_status = paddr == `OFS_REQUEST_STATUS;
  wire hit_ctrl = paddr == `OFS_MATCH_CONTROL;
  wire hit_src = paddr == `OFS_SLICE_SOURCE;
  wire hit_cfg = paddr == `OFS_SLICE_CONFIG;
  wire hit_psel = paddr >= `OFS_PIN_SELECT_BASE && paddr <= `OFS_PIN_SELECT_LAST
    && paddr[1:0] == 2'h0;
  wire [2:0] psel_index = paddr[4:2];
  wire hit_any = hit_sense || hit_enr || hit_senr || hit_cenr || hit_enf || hit_senf
    || hit_cenf || hit_rise || hit_fall || hit_status || hit_ctrl || hit_src
    || hit_cfg || hit_psel;
  wire [7:0] wbyte = pwdata[7:0];

  // zero wait states; read data is captured during setup so it comes from a flop
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  // ----------------------------------------------------------------
  // channel inputs
  // ----------------------------------------------------------------
  chan_vec_t chan_now;
  chan_vec_t chan_prev;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : chan_mux
      assign chan_now[g] = pad_sync[channel_pin_select[g]];
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      chan_prev <= `RESET_BYTE;
    end else begin
      chan_prev <= chan_now;
    end
  end

  wire [7:0] chan_rise = chan_now & ~chan_prev;
  wire [7:0] chan_fall = ~chan_now & chan_prev;

  // ----------------------------------------------------------------
  // pin interrupt requests
  // ----------------------------------------------------------------
  // level channels: enable and level match; edge channels: latched detectors
  wire [7:0] level_hit = ~(chan_now ^ fall_active_level_bits);
  wire [7:0] level_request = channel_sense_select & rise_or_level_enable_bits
    & level_hit;
  wire [7:0] edge_request = ~channel_sense_select & (rise_detect | fall_detect);
  wire [7:0] pin_request = level_request | edge_request;

  wire [7:0] status_clear = (write_strobe && hit_status) ? wbyte : `RESET_BYTE;
  wire [7:0] rise_clear = ((write_strobe && hit_rise) ? wbyte : `RESET_BYTE)
    | (status_clear & ~channel_sense_select);
  wire [7:0] fall_clear = ((write_strobe && hit_fall) ? wbyte : `RESET_BYTE)
    | (status_clear & ~channel_sense_select);
  // detectors record edges on enabled edge channels; a new edge beats a clear
  wire [7:0] rise_set = chan_rise & ~channel_sense_select & rise_or_level_enable_bits;
  wire [7:0] fall_set = chan_fall & ~channel_sense_select & fall_active_level_bits;
  wire [7:0] next_rise_detect = (rise_detect & ~rise_clear) | rise_set;
  wire [7:0] next_fall_detect = (fall_detect & ~fall_clear) | fall_set;

  // writing ones to status in level mode flips the active level
  wire [7:0] level_toggle = status_clear & channel_sense_select;
  wire [7:0] next_enr = hit_enr ? wbyte
    : hit_senr ? (rise_or_level_enable_bits | wbyte)
    : hit_cenr ? (rise_or_level_enable_bits & ~wbyte)
    : rise_or_level_enable_bits;
  wire [7:0] next_enf = hit_enf ? wbyte
    : hit_senf ? (fall_active_level_bits | wbyte)
    : hit_cenf ? (fall_active_level_bits & ~wbyte)
    : fall_active_level_bits ^ level_toggle;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      channel_sense_select <= `RESET_BYTE;
      rise_or_level_enable_bits <= `RESET_BYTE;
      fall_active_level_bits <= `RESET_BYTE;
      rise_detect <= `RESET_BYTE;
      fall_detect <= `RESET_BYTE;
    end else begin
      if (write_strobe && hit_sense) begin
        channel_sense_select <= wbyte;
      end
      if (write_strobe) begin
        rise_or_level_enable_bits <= next_enr;
      end
      fall_active_level_bits <= write_strobe ? next_enf
        : fall_active_level_bits ^ level_toggle;
      rise_detect <= next_rise_detect;
      fall_detect <= next_fall_detect;
    end
  end

  // ----------------------------------------------------------------
  // control, slice and pin select registers
  // ----------------------------------------------------------------
  // any rewrite of the expression restarts every sticky detector
  wire sticky_clear = write_strobe && (hit_ctrl || hit_src || hit_cfg);

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      match_select <= 1'b0;
      event_enable <= 1'b0;
      slice_source <= `RESET_WORD;
      slice_config <= `RESET_WORD;
    end else begin
      if (write_strobe && hit_ctrl) begin
        match_select <= pwdata[`CTRL_MATCH_SELECT_BIT];
        event_enable <= pwdata[`CTRL_EVENT_ENABLE_BIT];
      end
      if (write_strobe && hit_src) begin
        slice_source <= pwdata;
      end
      if (write_strobe && hit_cfg) begin
        slice_config <= pwdata;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < 8; i++) begin
        channel_pin_select[i] <= `RESET_PIN_SELECT;
      end
    end else if (write_strobe && hit_psel) begin
      channel_pin_select[psel_index] <= pwdata[5:0];
    end
  end

  // ----------------------------------------------------------------
  // pattern match slices
  // ----------------------------------------------------------------
  function automatic field_t field_of(input logic [31:0] word, input int unsigned n);
    field_of = word[`SRC_FIELD_LSB + `FIELD_WIDTH * n +: `FIELD_WIDTH];
  endfunction

  // combines the detector state with the present inputs into the slice output
  function automatic logic slice_true(input field_t mode, input logic level,
      input logic rise, input logic fall, input logic sticky);
    case (mode)
      `SLICE_ALWAYS: slice_true = 1'b1;
      `SLICE_STICKY_RISE: slice_true = sticky || rise;
      `SLICE_STICKY_FALL: slice_true = sticky || fall;
      `SLICE_STICKY_BOTH: slice_true = sticky || rise || fall;
      `SLICE_LEVEL_HIGH: slice_true = level;
      `SLICE_LEVEL_LOW: slice_true = !level;
      `SLICE_NEVER: slice_true = 1'b0;
      default: slice_true = rise || fall;
    endcase
  endfunction

  chan_vec_t slice_sticky;
  chan_vec_t slice_out;
  chan_vec_t slice_last;
  chan_vec_t term_product;
  chan_vec_t minterm_match;
  chan_vec_t next_sticky;

  generate
    for (g = 0; g < 8; g++) begin : slice
      wire [2:0] src = field_of(slice_source, g);
      wire field_t mode = field_of(slice_config, g);
      wire s_level = chan_now[src];
      wire s_rise = chan_rise[src];
      wire s_fall = chan_fall[src];
      assign slice_out[g] = slice_true(mode, s_level, s_rise, s_fall, slice_sticky[g]);
      // an edge in the clearing cycle still sets the detector, so no edge is lost
      assign next_sticky[g] = slice_true(mode, s_level, s_rise, s_fall,
        slice_sticky[g] && !sticky_clear)
        && (mode == `SLICE_STICKY_RISE || mode == `SLICE_STICKY_FALL
        || mode == `SLICE_STICKY_BOTH);
      if (g == 7) begin : tail
        assign slice_last[g] = 1'b1;
      end else begin : body
        assign slice_last[g] = slice_config[g];
      end
      if (g == 0) begin : first
        assign term_product[g] = slice_out[g];
      end else begin : chain
        // a slice continues the product unless the previous slice closed a minterm
        assign term_product[g] = slice_out[g]
          && (slice_last[g-1] || term_product[g-1]);
      end
      assign minterm_match[g] = slice_last[g] && term_product[g];
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      slice_sticky <= `RESET_BYTE;
    end else begin
      slice_sticky <= next_sticky;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // pattern logic is purely clocked, and so is the pin path; only pin requests (level or edge) drive wake, and only while the clock runs
  wire any_match = |minterm_match;
  wire [7:0] next_request = match_select ? minterm_match : pin_request;
  wire next_wake = !match_select && (|pin_request);

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      interrupt_request <= `RESET_BYTE;
      any_match_output <= 1'b0;
      core_receive_event <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      interrupt_request <= next_request;
      any_match_output <= any_match;
      core_receive_event <= event_enable && any_match;
      wake_request <= next_wake;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire [31:0] read_mux = hit_sense ? {24'h0, channel_sense_select}
    : hit_enr ? {24'h0, rise_or_level_enable_bits}
    : hit_enf ? {24'h0, fall_active_level_bits}
    : hit_rise ? {24'h0, rise_detect}
    : hit_fall ? {24'h0, fall_detect}
    : hit_status ? {24'h0, pin_request}
    : hit_ctrl ? {minterm_match, 22'h0, event_enable, match_select}
    : hit_src ? slice_source
    : hit_cfg ? slice_config
    : hit_psel ? {26'h0, channel_pin_select[psel_index]}
    : 32'h0;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata <= `RESET_WORD;
    end else if (setup_phase && !pwrite) begin
      prdata <= read_mux;
    end
  end

endmodule
`default_nettype wire

// [pint_checker_assertions.sv]
// port-level checks for the pin interrupt and pattern match block
// assumes a bind onto the top module; control bits are tracked from apb writes
`timescale 1ns/1ps
`default_nettype none
module pint_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [63:0] pad_in,
  input wire logic [7:0] interrupt_request,
  input wire logic any_match_output,
  input wire logic core_receive_event,
  input wire logic wake_request
);
  // ----------------
  // helper state
  // ----------------
  logic match_sel;
  logic ev_en;
  logic [3:0] quiet;
  logic [63:0] pad_q;
  wire logic wr = psel && penable && pwrite;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      match_sel <= 1'b0;
      ev_en <= 1'b0;
      quiet <= 4'h0;
      pad_q <= 64'h0;
    end else begin
      pad_q <= pad_in;
      // any write may reconfigure, so quiet time restarts there too
      quiet <= (wr || pad_in != pad_q) ? 4'h0 : (quiet == 4'hf ? quiet : quiet + 4'h1);
      if (wr && paddr == 12'h028) begin
        match_sel <= pwdata[0];
        ev_en <= pwdata[1];
      end
    end
  end
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_event_needs_match: assert property (core_receive_event |-> any_match_output)
    else $error("receive event without a match");
  a_event_needs_enable: assert property (core_receive_event |-> ev_en || $past(ev_en))
    else $error("receive event while disabled");
  a_event_follows_match: assert property (ev_en && $past(ev_en) |-> core_receive_event == any_match_output)
    else $error("receive event differs from match");
  a_wake_needs_request: assert property (wake_request |-> |interrupt_request)
    else $error("wake without request");
  a_pattern_no_wake: assert property (match_sel && $past(match_sel) |-> !wake_request)
    else $error("wake in pattern mode");
  a_pin_mode_wake: assert property (!match_sel && !$past(match_sel) |-> wake_request == |interrupt_request)
    else $error("wake differs from pin requests");
  a_lines_match_or: assert property (match_sel && $past(match_sel) |-> (|interrupt_request) == any_match_output)
    else $error("request lines differ from match");
  a_quiet_stable: assert property (quiet >= 4'h6 |-> $stable(interrupt_request) && $stable(any_match_output))
    else $error("outputs moved without cause");
endmodule
`default_nettype wire

// [pad_source.sv]
// partner model: raw pads of ports 0 and 1
// assumes the bench calls drive() from its main sequence
`timescale 1ns/1ps
`default_nettype none
module pad_source (
  input wire logic clock,
  output logic [63:0] pad_in
);
  // pads carry raw levels whatever function the pin has
  initial pad_in = 64'h0;
  task automatic drive(input int idx, input logic val);
    @(posedge clock);
    pad_in[idx] <= val;
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the pin interrupt and pattern match block
// assumes the design files and pint_regs.svh are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "pint_regs.svh"
module tb_top;
  import pint_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic last_err;
  logic [63:0] pad_in;
  logic [7:0] interrupt_request;
  logic any_match_output;
  logic core_receive_event;
  logic wake_request;
  int failures = 0;
  int check_count = 0;
  always #50 clock = ~clock;
  pad_source pads_u (.clock(clock), .pad_in(pad_in));
  pin_interrupt_pattern_match dut_u (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .interrupt_request(interrupt_request),
    .any_match_output(any_match_output), .core_receive_event(core_receive_event),
    .wake_request(wake_request));
  // ----------------
  // tasks
  // ----------------
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // no wait limit here: only the watchdog may end a stalled transfer
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    compare(q, exp);
  endtask
  task automatic lines(input int wait_n, input logic [7:0] exp);
    repeat (wait_n) @(negedge clock);
    compare({24'h0, interrupt_request}, {24'h0, exp});
  endtask
  // counts request and event cycles after one pad change
  task automatic toggle(input int idx, input logic v, input int e_irq, input int e_ev,
                        input int e_any);
    int n_irq;
    int n_ev;
    int n_any;
    n_irq = 0;
    n_ev = 0;
    n_any = 0;
    pads_u.drive(idx, v);
    repeat (10) begin
      @(negedge clock);
      if (interrupt_request === 8'h02) n_irq++;
      if (core_receive_event === 1'b1) n_ev++;
      if (any_match_output === 1'b1) n_any++;
    end
    compare(32'(n_irq), 32'(e_irq));
    compare(32'(n_ev), 32'(e_ev));
    compare(32'(n_any), 32'(e_any));
  endtask
  function automatic logic [31:0] cfg(input logic [2:0] m0);
    logic [31:0] w;
    w = 32'h2;
    w[10:8] = m0;
    w[13:11] = `SLICE_EVENT_BOTH;
    for (int k = 2; k < 8; k++) w[8 + 3 * k +: 3] = `SLICE_NEVER;
    return w;
  endfunction
  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------
  // sequence
  // ----------------
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
    rd(12'h034, 32'h0);
    compare({31'h0, last_err}, 32'h1);
    wr(12'h008, 32'h05);
    wr(12'h008, 32'h02);
    rd(12'h004, 32'h07);
    wr(12'h00c, 32'h01);
    rd(12'h004, 32'h06);
    wr(12'h044, 32'h23);
    rd(12'h044, 32'h23);
    pads_u.drive(35, 1'b1);
    lines(8, 8'h02);
    compare({31'h0, wake_request}, 32'h1);
    rd(12'h024, 32'h02);
    wr(12'h01c, 32'h02);
    lines(3, 8'h00);
    wr(12'h000, 32'h04);
    wr(12'h010, 32'h04);
    pads_u.drive(0, 1'b1);
    lines(8, 8'h04);
    wr(12'h018, 32'h04);
    lines(4, 8'h00);
    wr(12'h02c, 32'h0000_0a00);
    wr(12'h030, cfg(`SLICE_LEVEL_HIGH));
    wr(12'h028, 32'h03);
    toggle(35, 1'b0, 1, 1, 1);
    pads_u.drive(0, 1'b0);
    toggle(35, 1'b1, 0, 0, 0);
    wr(12'h030, cfg(`SLICE_STICKY_RISE));
    toggle(35, 1'b0, 0, 0, 0);
    pads_u.drive(0, 1'b1);
    toggle(35, 1'b1, 1, 1, 1);
    toggle(35, 1'b0, 1, 1, 1);
    // pin lines with the receive event still enabled, then the event disabled
    wr(12'h030, cfg(`SLICE_LEVEL_HIGH));
    wr(12'h028, 32'h02);
    wr(12'h024, 32'h02);
    toggle(35, 1'b1, 6, 1, 1);
    wr(12'h028, 32'h00);
    toggle(35, 1'b0, 10, 0, 1);
    complete_run();
  end
  initial begin
    #500000;
    failures++;
    complete_run();
  end
endmodule
bind pin_interrupt_pattern_match pint_checker chk_u (.clock(clock), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pad_in(pad_in),
  .interrupt_request(interrupt_request), .any_match_output(any_match_output),
  .core_receive_event(core_receive_event), .wake_request(wake_request));
`default_nettype wire
